/* File: dv/dbn_node_params_props.sv */
// Purpose : Port-level properties of the node parameter bank
// Assumes : Bound to dbn_node_params, one clock domain
// Notes   : Slot checks split over the two buses to save space
`timescale 1ns/1ps

module dbn_node_params_props
(
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_ACK_O,
    input wire logic        CRC_GEN_CAPABLE,
    input wire logic        HOB_CAPABLE,
    input wire logic        BUS_ID_VALID,
    input wire logic [1:0]  SLOT_OFFER,
    input wire logic [1:0]  SLOT_USE,
    input wire logic [1:0]  SLOT_SKIP,
    input wire logic        CRC_APPEND,
    input wire logic        TYPE12_ENABLE,
    input wire logic [15:0] PRIO_MAP,
    input wire logic [6:0]  BAL_MOD
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // ==========================================================
    // Map ordering helper; entry 0 at 3 is caught through entry 1
    logic prio_ok;
    always_comb
    begin
        prio_ok = 1'b1;
        for (int j = 1; j < 8; j++)
        begin
            if (PRIO_MAP[2*j +: 2] == 2'h3 || PRIO_MAP[2*j +: 2] < PRIO_MAP[2*j-2 +: 2])
                prio_ok = 1'b0;
        end
    end

    // ==========================================================
    // Properties
    ack_one_cycle_a:
    assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("bus request not acknowledged for exactly one cycle");
    ack_no_req_a:
    assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
        else $error("acknowledge without a request");
    slot_answer_a:
    assert property (SLOT_OFFER[0] |=> SLOT_USE[0] != SLOT_SKIP[0])
        else $error("bus A offer not answered exactly once");
    slot_idle_a:
    assert property (!SLOT_OFFER[1] |=> !SLOT_USE[1] && !SLOT_SKIP[1])
        else $error("bus B answer without an offer");
    bal_off_a:
    assert property (BAL_MOD == 7'h00 && $past(BAL_MOD) == 7'h00 && SLOT_OFFER[0] |=> SLOT_USE[0])
        else $error("slot skipped with balancing disabled");
    mod_range_a:
    assert property (BAL_MOD <= 7'h40)
        else $error("modulus above 64");
    prio_order_a:
    assert property (prio_ok)
        else $error("priority map decreasing or out of range");
    crc_gen_cap_a:
    assert property ($rose(CRC_APPEND) |-> $past(CRC_GEN_CAPABLE, 4))
        else $error("crc append enabled without capability");
    t12_gate_a:
    assert property ($rose(TYPE12_ENABLE) |-> $past(BUS_ID_VALID, 4) && $past(HOB_CAPABLE, 4))
        else $error("type 1/2 functions enabled without id or capability");
endmodule

bind dbn_node_params dbn_node_params_props dbn_node_params_props_inst (
    .CLK(CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
    .CRC_GEN_CAPABLE(CRC_GEN_CAPABLE), .HOB_CAPABLE(HOB_CAPABLE),
    .BUS_ID_VALID(BUS_ID_VALID), .SLOT_OFFER(SLOT_OFFER), .SLOT_USE(SLOT_USE),
    .SLOT_SKIP(SLOT_SKIP), .CRC_APPEND(CRC_APPEND), .TYPE12_ENABLE(TYPE12_ENABLE),
    .PRIO_MAP(PRIO_MAP), .BAL_MOD(BAL_MOD));

/* File: dv/tb_top.sv */
// Purpose : Self-checking bench for the node parameter bank
// Assumes : Wishbone answer comes one cycle after the taken edge
// Notes   : Periods checked at their defaults, then rewritten to 28000001 and 100 by the range test
`timescale 1ns/1ps

`define CHK(nm, e, g) \
    begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module tb_top;
    logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, dat_o, reasm, hob;
    logic        ack, t12_en, dflt_en, crc_app, crc_chk;
    logic        hob_cap = 1'b0, gen_cap = 1'b0, chk_cap = 1'b0, bus_id = 1'b0, is_dflt = 1'b1;
    logic [1:0]  offer = 2'h0, use_o, skip_o, exp_use = 2'h0, exp_skip = 2'h0;
    logic [15:0] prio, v;
    logic [9:0]  rsv, maxp;
    logic [6:0]  bmod;
    logic        bal_on = 1'b0, ok;
    int          error_cnt = 0, samples_checked = 0, seed = 17, m_mod = 8, cnt[2] = '{0, 0};
    int          pend[2] = '{0, 0};
    logic [15:0] ptab[4] = '{16'haa50, 16'h0004, 16'hffff, 16'h0000};
    logic [5:0]  ra[8] = '{6'h18, 6'h18, 6'h10, 6'h10, 6'h14, 6'h04, 6'h08, 6'h18};
    logic [31:0] rv[8] = '{64, 65, 1023, 1024, 5, 28000001, 100, 0};
    logic [31:0] rx[8] = '{64, 64, 1023, 1023, 5, 28000001, 100, 0};
    logic [7:0]  ctab[6] = '{8'h4f, 8'hbf, 8'hf1, 8'hcf, 8'h42, 8'hc2};
    logic [3:0]  cexp[6] = '{4'h2, 4'he, 4'h1, 4'h3, 4'h3, 4'h2};
    logic [6:0]  mods[4] = '{7'h00, 7'h01, 7'h03, 7'h40};

    always #12.5 clk = ~clk;

    dbn_node_params dbn_node_params_inst (
        .CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .HOB_CAPABLE(hob_cap), .CRC_GEN_CAPABLE(gen_cap), .CRC_CHK_CAPABLE(chk_cap),
        .BUS_ID_VALID(bus_id), .IS_DEFAULT_NODE(is_dflt), .SLOT_OFFER(offer),
        .SLOT_USE(use_o), .SLOT_SKIP(skip_o), .TYPE12_ENABLE(t12_en),
        .DEFAULT_ENABLE(dflt_en), .CRC_APPEND(crc_app), .CRC_CHECK(crc_chk),
        .REASM_PERIOD(reasm), .HOB_PERIOD(hob), .PRIO_MAP(prio), .RSV_PAGES(rsv),
        .MAX_PAGES(maxp), .BAL_MOD(bmod));

    // ==========================================================
    // Bus master: hold the request until ack is sampled high
    task automatic wb(input logic [5:0] a, input logic w, input logic [31:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        // Only the watchdog ends a wait for the acknowledge
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
        wb(a, 1'b0, 32'h0);
        `CHK(nm, e, rdat)
    endtask

    // Status word as the pins and the last write should leave it
    function automatic logic [31:0] stat(input logic refused);
        return {26'h0, is_dflt, chk_cap, gen_cap, hob_cap, bus_id, refused};
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // Balancing model: n uses then one skip per bus, all uses at zero;
    // a pending skip survives a modulus change
    always @(posedge clk)
    begin
        if (bal_on)
        begin
            `CHK("slot_use", exp_use, use_o)
            `CHK("slot_skip", exp_skip, skip_o)
            for (int g = 0; g < 2; g++)
            begin
                exp_use[g] = offer[g] && (m_mod == 0 || pend[g] == 0);
                exp_skip[g] = offer[g] && !exp_use[g];
                if (offer[g])
                begin
                    pend[g] = 0;
                    if (m_mod == 0)
                        cnt[g] = 0;
                    else if (exp_use[g])
                        cnt[g] = cnt[g] + 1;
                    if (m_mod != 0 && cnt[g] >= m_mod)
                    begin
                        cnt[g] = 0;
                        pend[g] = 1;
                    end
                end
            end
        end
    end

    // Watchdog well beyond the thousand or so cycles the tests need
    initial
    begin
        #(25 * 20000);
        error_cnt++;
        final_report();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK("reasm", 32'd28000000, reasm)
        `CHK("hob", 32'd200000000, hob)
        `CHK("prio", 16'h0000, prio)
        `CHK("rsv", 10'h000, rsv)
        `CHK("maxp", 10'h001, maxp)
        `CHK("bmod", 7'h08, bmod)
        `CHK("dflt_en", 1'b1, dflt_en)
        rd(6'h00, 32'h2, "ctrl");
        wb(6'h20, 1'b1, 32'hffff_ffff);
        rd(6'h20, 32'h0, "unmapped");
        $display("test defaults done");
        for (int i = 0; i < 12; i++)
        begin
            v = (i < 4) ? ptab[i] : 16'($random(seed));
            ok = (v[1:0] != 2'h3);
            for (int j = 1; j < 8; j++)
                if (v[2*j +: 2] == 2'h3 || v[2*j +: 2] < v[2*j-2 +: 2]) ok = 1'b0;
            wb(6'h0c, 1'b1, {16'h0, v});
            rd(6'h1c, stat(!ok), "status");
            if (ok) `CHK("prio_out", v, prio)
        end
        $display("test priority map done");
        for (int i = 0; i < 8; i++)
        begin
            wb(ra[i], 1'b1, rv[i]);
            rd(6'h1c, stat(rv[i] != rx[i]), "status");
            rd(ra[i], rx[i], "range");
        end
        `CHK("rsv_out", 10'h3ff, rsv)
        `CHK("bmod_out", 7'h00, bmod)
        `CHK("hob_out", 32'd100, hob)
        `CHK("maxp_out", 10'h005, maxp)
        // Byte enables merge over the old value before the range check
        sel <= 4'h2;
        wb(6'h10, 1'b1, 32'hffff_0100);
        sel <= 4'hf;
        rd(6'h10, 32'h0000_01ff, "sel_merge");
        $display("test ranges done");
        is_dflt <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            {bus_id, hob_cap, gen_cap, chk_cap} <= ctab[i][7:4];
            repeat (6) @(posedge clk);
            wb(6'h00, 1'b1, {28'h0, ctab[i][3:0]});
            rd(6'h00, {28'h0, cexp[i]}, "ctrl");
            `CHK("crc_app", cexp[i][2], crc_app)
            `CHK("crc_chk", cexp[i][3], crc_chk)
            `CHK("t12_en", cexp[i][0], t12_en)
            `CHK("dflt_en", 1'b0, dflt_en)
        end
        wb(6'h00, 1'b1, 32'h3);
        is_dflt <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK("t12_en", 1'b0, t12_en)
        `CHK("dflt_en", 1'b1, dflt_en)
        $display("test flags done");
        foreach (mods[k])
        begin
            wb(6'h18, 1'b1, {25'h0, mods[k]});
            m_mod = mods[k];
            repeat (3) @(posedge clk);
            bal_on <= 1'b1;
            repeat (150)
            begin
                offer <= (k == 0) ? 2'h3 : 2'($random(seed));
                @(posedge clk);
            end
            offer <= 2'h0;
            repeat (3) @(posedge clk);
            bal_on <= 1'b0;
            $display("test balancing modulus %0d done", mods[k]);
        end
        final_report();
    end
endmodule

/* File: rtl/dbn_defines.svh */
// Purpose : Offsets, field positions, reset values and timing for the node parameter bank
// Assumes : Included by its bare name from the top module
// Notes   : Definitions only
`ifndef DBN_DEFINES_SVH
`define DBN_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define DBN_OFS_CTRL      6'h00
`define DBN_OFS_REASM     6'h04
`define DBN_OFS_HOB       6'h08
`define DBN_OFS_PRIO      6'h0c
`define DBN_OFS_RSVPG     6'h10
`define DBN_OFS_MAXPG     6'h14
`define DBN_OFS_BALMOD    6'h18
`define DBN_OFS_STATUS    6'h1c

// ==========================================================
// Control register field positions
`define DBN_CTRL_T12      0
`define DBN_CTRL_DFLT     1
`define DBN_CTRL_CRCGEN   2
`define DBN_CTRL_CRCCHK   3

// ==========================================================
// Reset values
`define DBN_RST_T12       1'b0
`define DBN_RST_DFLT      1'b1
`define DBN_RST_CRCGEN    1'b0
`define DBN_RST_CRCCHK    1'b0
`define DBN_RST_PRIO      16'h0000
`define DBN_RST_RSVPG     10'h000
`define DBN_RST_MAXPG     10'h001
`define DBN_RST_BALMOD    7'h08
`define DBN_MAX_BALMOD    7'h40

// ==========================================================
// Timing: periods in ms, rate in kHz
`define DBN_REASM_MS      700
`define DBN_HOB_MS        5000
`define DBN_CLK_KHZ       40000

`endif

/* File: rtl/dbn_node_params.sv */
// Purpose : Node management parameter bank with bandwidth balancing
// Assumes : Classic Wishbone slave, one clock, capability pins asynchronous
// Notes   : Periods held in clock cycles; refused writes leave old values, for control only the refused bits
//
// Summary of operation
// - Reassembly period resets to at least 0.7 s
// - Head-of-bus timer period resets to 5 s
// - Eight priority entries, each level 0..2
// - Refuse priority writes that decrease along index
// - Priority entries reset to zero
// - Reserved pages reset zero, range 10 bits
// - Maximum pages resets to one
// - Modulus accepts 0..64, resets to 8
// - Modulus zero disables balancing
// - Use at most n of n+1 slots
// - Type-1/2 flag normal runs, disabled idles
// - Type-1/2 flag resets disabled
// - Type-1/2 flag frozen until bus identity seen
// - Type-1/2 normal needs head-of-bus capability
// - Default-node flag resets normal, freely writable
// - Generate flag drives CRC append
// - Generate flag resets off, on needs capability
// - Verify flag drives CRC checking
// - Verify flag resets off, on needs capability
// - Role strap selects default or type-1 functions
// - Per-bus counter picks skipped empty slots
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "dbn_defines.svh"

module dbn_node_params
    import dbn_pkg::*;
#(
    parameter int unsigned REASM_CYC = `DBN_REASM_MS * `DBN_CLK_KHZ,
    parameter int unsigned HOB_CYC   = `DBN_HOB_MS * `DBN_CLK_KHZ,
    parameter int unsigned PAGE_W    = 10
)
(
    input  wire  logic        CLK,
    input  wire  logic        RSTN,
    input  wire  logic        WB_CYC_I,
    input  wire  logic        WB_STB_I,
    input  wire  logic        WB_WE_I,
    input  wire  logic [5:0]  WB_ADR_I,
    input  wire  logic [3:0]  WB_SEL_I,
    input  wire  logic [31:0] WB_DAT_I,
    output logic       [31:0] WB_DAT_O,
    output logic              WB_ACK_O,
    input  wire  logic        HOB_CAPABLE,
    input  wire  logic        CRC_GEN_CAPABLE,
    input  wire  logic        CRC_CHK_CAPABLE,
    input  wire  logic        BUS_ID_VALID,
    input  wire  logic        IS_DEFAULT_NODE,
    input  wire  logic [1:0]  SLOT_OFFER,
    output logic       [1:0]  SLOT_USE,
    output logic       [1:0]  SLOT_SKIP,
    output logic              TYPE12_ENABLE,
    output logic              DEFAULT_ENABLE,
    output logic              CRC_APPEND,
    output logic              CRC_CHECK,
    output logic       [31:0] REASM_PERIOD,
    output logic       [31:0] HOB_PERIOD,
    output logic       [15:0] PRIO_MAP,
    output logic       [9:0]  RSV_PAGES,
    output logic [PAGE_W-1:0] MAX_PAGES,
    output logic       [6:0]  BAL_MOD
);

    // ======================================================
    // Elaboration checks: the read mux holds at most 32 page bits
    if (PAGE_W < 1 || PAGE_W > 32 || REASM_CYC < `DBN_REASM_MS * `DBN_CLK_KHZ || HOB_CYC == 0)
    begin : g_bad_params
        $error("Parameter values out of range");
    end

    // ======================================================
    // Reset release and pin synchronisers
    logic        rst_a_q;
    logic        rst_n_q;
    dbn_pins_s   pins_m_q;
    dbn_pins_s   pins_q;

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rst_a_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_a_q <= 1'b1;
            rst_n_q <= rst_a_q;
        end
    end

    // Two stages; the first is read only by the second
    always_ff @(posedge CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pins_m_q <= '0;
            pins_q   <= '0;
        end
        else
        begin
            pins_m_q <= {IS_DEFAULT_NODE, CRC_CHK_CAPABLE, CRC_GEN_CAPABLE,
                         HOB_CAPABLE, BUS_ID_VALID};
            pins_q   <= pins_m_q;
        end
    end

    // ======================================================
    // Helper functions
    // Byte-enable merge of write data over the old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                r[b*8 +: 8] = nw[b*8 +: 8];
        return r;
    endfunction

    // Priority map legal: levels 0..2 and nondecreasing
    function automatic logic prio_ok(input logic [15:0] m);
        logic ok;
        ok = 1'b1;
        for (int j = 0; j < 8; j++)
        begin
            if (m[j*2 +: 2] == 2'h3)
                ok = 1'b0;
            if (j > 0 && m[j*2 +: 2] < m[(j-1)*2 +: 2])
                ok = 1'b0;
        end
        return ok;
    endfunction

    // ======================================================
    // Wishbone access: ack one cycle after the request, writes at the ack edge
    logic        req;
    logic        commit;
    logic [31:0] rd_word;
    logic [31:0] wr_word;
    logic        wr_ok;
    logic        refused_q;
    dbn_flags_s  flags_q;
    dbn_flags_s  flags_new;
    logic [31:0] reasm_q;
    logic [31:0] hob_q;
    logic [15:0] prio_q;
    logic [9:0]  rsv_q;
    logic [PAGE_W-1:0] maxpg_q;
    logic [6:0]  mod_q;

    assign req    = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign commit = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;

    // Read mux; unmapped offsets read as zero
    always_comb
    begin
        unique case (WB_ADR_I)
            `DBN_OFS_CTRL:   rd_word = {28'h0, flags_q};
            `DBN_OFS_REASM:  rd_word = reasm_q;
            `DBN_OFS_HOB:    rd_word = hob_q;
            `DBN_OFS_PRIO:   rd_word = {16'h0, prio_q};
            `DBN_OFS_RSVPG:  rd_word = {22'h0, rsv_q};
            `DBN_OFS_MAXPG:  rd_word = 32'(maxpg_q);
            `DBN_OFS_BALMOD: rd_word = {25'h0, mod_q};
            `DBN_OFS_STATUS: rd_word = {26'h0, pins_q, refused_q};
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end
        else
        begin
            WB_ACK_O <= req;
            if (req && !WB_WE_I)
                WB_DAT_O <= rd_word;
        end
    end

    // ======================================================
    // Write value and its legality
    assign wr_word = merge(rd_word, WB_DAT_I, WB_SEL_I);

    // Flag filtering: refused bits keep their old value
    always_comb
    begin
        flags_new = flags_q;
        if (pins_q.bus_id_ok)
        begin
            if (!wr_word[`DBN_CTRL_T12] || pins_q.hob_cap)
                flags_new.t12 = wr_word[`DBN_CTRL_T12];
        end
        flags_new.dflt = wr_word[`DBN_CTRL_DFLT];
        if (!wr_word[`DBN_CTRL_CRCGEN] || pins_q.gen_cap)
            flags_new.crc_gen = wr_word[`DBN_CTRL_CRCGEN];
        if (!wr_word[`DBN_CTRL_CRCCHK] || pins_q.chk_cap)
            flags_new.crc_chk = wr_word[`DBN_CTRL_CRCCHK];
    end

    // Write accepted unless a control, priority, reserved-page or modulus field would not land as written
    always_comb
    begin
        unique case (WB_ADR_I)
            `DBN_OFS_CTRL:   wr_ok = (flags_new == dbn_flags_s'(wr_word[3:0]));
            `DBN_OFS_PRIO:   wr_ok = prio_ok(wr_word[15:0]);
            `DBN_OFS_RSVPG:  wr_ok = (wr_word[31:10] == 22'h0);
            `DBN_OFS_BALMOD: wr_ok = (wr_word <= 32'(`DBN_MAX_BALMOD));
            default:         wr_ok = 1'b1;
        endcase
    end

    // Last write outcome, updated by each write
    always_ff @(posedge CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
            refused_q <= 1'b0;
        else if (commit)
            refused_q <= !wr_ok;
    end

    // ======================================================
    // Flags
    always_ff @(posedge CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            flags_q.t12     <= `DBN_RST_T12;
            flags_q.dflt    <= `DBN_RST_DFLT;
            flags_q.crc_gen <= `DBN_RST_CRCGEN;
            flags_q.crc_chk <= `DBN_RST_CRCCHK;
        end
        else if (commit && WB_ADR_I == `DBN_OFS_CTRL)
            flags_q <= flags_new;
    end

    // ======================================================
    // Timer periods, in clock cycles
    always_ff @(posedge CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            reasm_q <= 32'(REASM_CYC);
            hob_q   <= 32'(HOB_CYC);
        end
        else if (commit)
        begin
            if (WB_ADR_I == `DBN_OFS_REASM)
                reasm_q <= wr_word;
            if (WB_ADR_I == `DBN_OFS_HOB)
                hob_q <= wr_word;
        end
    end

    // ======================================================
    // Priority map and page limits
    always_ff @(posedge CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            prio_q  <= `DBN_RST_PRIO;
            rsv_q   <= `DBN_RST_RSVPG;
            maxpg_q <= PAGE_W'(`DBN_RST_MAXPG);
        end
        else if (commit && wr_ok)
        begin
            if (WB_ADR_I == `DBN_OFS_PRIO)
                prio_q <= wr_word[15:0];
            if (WB_ADR_I == `DBN_OFS_RSVPG)
                rsv_q <= wr_word[9:0];
            if (WB_ADR_I == `DBN_OFS_MAXPG)
                maxpg_q <= wr_word[PAGE_W-1:0];
        end
    end

    // Balancing modulus
    always_ff @(posedge CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
            mod_q <= `DBN_RST_BALMOD;
        else if (commit && wr_ok && WB_ADR_I == `DBN_OFS_BALMOD)
            mod_q <= wr_word[6:0];
    end

    // ======================================================
    // Bandwidth balancing, one counter per bus
    // Skip armed after n uses, so n of n+1 offers taken; count stays below 64
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_bus
            logic [5:0] cnt_q;
            logic       skip_q;

            always_ff @(posedge CLK or negedge rst_n_q)
            begin
                if (!rst_n_q)
                begin
                    cnt_q        <= 6'h00;
                    skip_q       <= 1'b0;
                    SLOT_USE[g]  <= 1'b0;
                    SLOT_SKIP[g] <= 1'b0;
                end
                else
                begin
                    SLOT_USE[g]  <= 1'b0;
                    SLOT_SKIP[g] <= 1'b0;
                    if (SLOT_OFFER[g])
                    begin
                        if (mod_q == 7'h00)
                        begin
                            SLOT_USE[g] <= 1'b1;
                            cnt_q       <= 6'h00;
                            skip_q      <= 1'b0;
                        end
                        else if (skip_q)
                        begin
                            SLOT_SKIP[g] <= 1'b1;
                            skip_q       <= 1'b0;
                        end
                        else
                        begin
                            SLOT_USE[g] <= 1'b1;
                            if ({1'b0, cnt_q} >= mod_q - 7'h01)
                            begin
                                cnt_q  <= 6'h00;
                                skip_q <= 1'b1;
                            end
                            else
                                cnt_q <= cnt_q + 6'h01;
                        end
                    end
                end
            end
        end
    endgenerate

    // ======================================================
    // Registered outputs to the node functions
    always_ff @(posedge CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            TYPE12_ENABLE  <= 1'b0;
            DEFAULT_ENABLE <= 1'b0;
            CRC_APPEND     <= 1'b0;
            CRC_CHECK      <= 1'b0;
        end
        else
        begin
            TYPE12_ENABLE  <= flags_q.t12 && !pins_q.is_default;
            DEFAULT_ENABLE <= flags_q.dflt && pins_q.is_default;
            CRC_APPEND     <= flags_q.crc_gen;
            CRC_CHECK      <= flags_q.crc_chk;
        end
    end

    // Parameter outputs come straight from their holding registers
    assign REASM_PERIOD = reasm_q;
    assign HOB_PERIOD   = hob_q;
    assign PRIO_MAP     = prio_q;
    assign RSV_PAGES    = rsv_q;
    assign MAX_PAGES    = maxpg_q;
    assign BAL_MOD      = mod_q;

endmodule

/* File: rtl/dbn_pkg.sv */
// Purpose : Types shared by the node parameter bank
// Assumes : Constants come from the defines header
// Notes   : Types only
package dbn_pkg;

    // ======================================================
    // Configuration and CRC flags, one bit each
    typedef struct packed {
        logic crc_chk;
        logic crc_gen;
        logic dflt;
        logic t12;
    } dbn_flags_s;

    // ======================================================
    // Synchronised capability and status pins
    typedef struct packed {
        logic is_default;
        logic chk_cap;
        logic gen_cap;
        logic hob_cap;
        logic bus_id_ok;
    } dbn_pins_s;

    // Eight two-bit priority map entries
    typedef logic [7:0][1:0] dbn_prio_t;

endpackage
